// ==== include/swpm_defines.svh ====
// swpm register block: offsets, field positions, reset values, timing counts
// assumes inclusion by bare name from the design files
`ifndef SWPM_DEFINES_SVH
`define SWPM_DEFINES_SVH
// register byte offsets
`define SWPM_OFS_PM_CAPABILITIES 8'h70
`define SWPM_OFS_PM_CONTROL_STATUS 8'h74
`define SWPM_OFS_PM_VENDOR_TIMERS_OR_STATE 8'h78
`define SWPM_OFS_SWITCH_STATUS 8'ha0
`define SWPM_OFS_SWITCH_CONTROL 8'ha4
// fixed capability values
`define SWPM_CAP_ID 8'h01
`define SWPM_NEXT_PTR 8'h00
`define SWPM_PM_VER 3'h2
`define SWPM_PME_SUPPORT 5'h19
// power state codes
`define SWPM_PS_D0 2'h0
`define SWPM_PS_D3HOT 2'h3
// field positions
`define SWPM_DEVICE_SPECIFIC_INIT_FLAG_BIT 21
`define SWPM_WAKE_MESSAGE_ENABLE_BIT 8
`define SWPM_WAKE_MESSAGE_STATUS_BIT 15
`define SWPM_MCS_BIT 31
`define SWPM_MARKER_LSB 13
`define SWPM_INTX_LSB 20
`define SWPM_CTL_RST_BIT 0
`define SWPM_CTL_HALT_BIT 1
`define SWPM_CTL_UNLOCK_BIT 2
`define SWPM_CTL_STRICT_BIT 3
// reset values
`define SWPM_DEEP_IDLE_ENTRY_TIMER_RST 16'h03e8
`define SWPM_STANDBY_ENTRY_TIMER_RST 12'h6d6
`define SWPM_POWER_FSM_STATE_CODE_RST 6'h3f
`define SWPM_UNLOCK_RST 1'b1
// timing
`define SWPM_CLK_PERIOD_NS 5
`define SWPM_US_NS 1000
`define SWPM_US_CYCLES ((`SWPM_US_NS + `SWPM_CLK_PERIOD_NS - 1) / `SWPM_CLK_PERIOD_NS)
`define SWPM_L0S_UNIT_NS 4
`define SWPM_SYNC_SETTLE 2
`endif

// ==== include/swpm_pkg.sv ====
// swpm package: shared types
// assumes swpm_defines.svh is on the include path
package swpm_pkg;
	// boot sequencer after fundamental reset release
	typedef enum logic [2:0] {
		SWPM_ST_SETTLE = 3'b001,
		SWPM_ST_CAPTURE = 3'b010,
		SWPM_ST_RUN = 3'b100
	} swpm_boot_type;
endpackage

// ==== src/swpm_sync2.sv ====
// swpm two-flop synchroniser for strap pins
// assumes inputs are asynchronous levels; output is stable two edges later
`timescale 1ns/1ps
module swpm_sync2 #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	// data
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_sync;

	// first stage is read only by the second stage
	always_comb begin
		next_meta = clk_en_i ? async_i : meta;
		next_sync = clk_en_i ? meta : sync_o;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta <= '0;
			sync_o <= '0;
		end else begin
			meta <= next_meta;
			sync_o <= next_sync;
		end
	end
endmodule

// ==== src/swpm_regs.sv ====
// swpm power management and switch control register block, one port
// assumes a single-cycle config access port on clk_i and same-clock
// inputs for pme, intx and pm state; strap pins are asynchronous
//
// Functional notes
// - capability id reads one, next pointer zero
// - version field reads two, read-only
// - D1 and D2 support bits read zero
// - PME support field reads fixed 0b11001
// - power state accepts only D0 and D3hot
// - sticky wake enable survives hot reset
// - own PME sets sticky w1c status bit, never on port A
// - bit 31 selects timer or state layout
// - deep idle timer in microseconds, upstream only
// - standby timer in 4 ns units
// - timer layout bits 30:28 read zero
// - state layout exposes six-bit fsm code
// - operating mode pins captured at reset exit
// - strap pins latched into status bits 4-11
// - sticky software marker field, read-write
// - status bits show aggregated INTA..INTD
// - control bit 0 write-one starts reset
// - hold bit keeps switch logic in reset
// - hold bit changes only during reset/init
// - unlock bit gates lockable field writes
// - strict ordering bit ignores relaxed ordering
// - pm data fields read zero
`timescale 1ns/1ps
`include "swpm_defines.svh"
module swpm_regs
	import swpm_pkg::*;
#(
	parameter bit PORT_IS_A = 1'b0,
	parameter bit IS_UPSTREAM = 1'b1,
	parameter int US_CYCLES = `SWPM_US_CYCLES
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	input wire logic hot_reset_i,
	// config access
	input wire logic cfg_req_i,
	input wire logic cfg_we_i,
	input wire logic [7:0] cfg_addr_i,
	input wire logic [3:0] cfg_be_i,
	input wire logic [31:0] cfg_wdata_i,
	output logic cfg_ack_o,
	output logic [31:0] cfg_rdata_o,
	// strap pins, asynchronous
	input wire logic [3:0] switch_operating_mode_i,
	input wire logic shared_refclk_downstream_i,
	input wire logic shared_refclk_upstream_i,
	input wire logic host_smbus_slow_strap_i,
	input wire logic port_a_lane_flip_i,
	input wire logic port_b_lane_flip_i,
	input wire logic port_c_lane_flip_i,
	input wire logic refclk_mode_strap_i,
	input wire logic hold_in_reset_i,
	// switch core status, same clock
	input wire logic eeprom_init_i,
	input wire logic pme_generate_i,
	input wire logic [5:0] power_fsm_state_code_i,
	input wire logic [3:0] intx_state_i,
	input wire logic standby_cond_i,
	input wire logic deep_idle_cond_i,
	// controls to the switch core
	output logic soft_reset_req_o,
	output logic hold_in_reset_o,
	output logic write_protect_release_o,
	output logic strict_ordering_force_o,
	output logic [1:0] port_power_state_o,
	output logic wake_message_enable_o,
	output logic standby_enter_o,
	output logic deep_idle_enter_o
);
	// elaboration check on the microsecond prescaler
	if (US_CYCLES < 1 || US_CYCLES > 255) begin : g_bad_us
		$error("US_CYCLES must lie in 1..255");
	end

	localparam logic [7:0] US_LAST = 8'(US_CYCLES - 1);
	localparam logic [15:0] CLK_NS = 16'(`SWPM_CLK_PERIOD_NS);

	// word address match
	function automatic logic swpm_hit(input logic [7:0] a, input logic [7:0] ofs);
		swpm_hit = (a[7:2] == ofs[7:2]);
	endfunction

	// byte enables expanded to a bit mask
	function automatic logic [31:0] swpm_mask(input logic [3:0] be);
		swpm_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// synchronised straps
	logic [11:0] strap_raw;
	logic [11:0] strap_sync;
	assign strap_raw = {hold_in_reset_i, refclk_mode_strap_i, port_c_lane_flip_i,
		port_b_lane_flip_i, port_a_lane_flip_i, host_smbus_slow_strap_i,
		shared_refclk_upstream_i, shared_refclk_downstream_i, switch_operating_mode_i};

	swpm_sync2 #(
		.WIDTH(12)
	) u_strap_sync (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.clk_en_i(clk_en_i),
		.async_i(strap_raw),
		.sync_o(strap_sync)
	);

	// register state
	swpm_boot_type boot;
	swpm_boot_type next_boot;
	logic [1:0] settle;
	logic [1:0] next_settle;
	logic [11:0] straps;
	logic [11:0] next_straps;
	logic device_specific_init_flag;
	logic next_device_specific_init_flag;
	logic [1:0] port_power_state;
	logic [1:0] next_port_power_state;
	logic wake_message_enable;
	logic next_wake_message_enable;
	logic wake_message_status;
	logic next_wake_message_status;
	logic layout_sel;
	logic next_layout_sel;
	logic [15:0] deep_idle_entry_timer;
	logic [15:0] next_deep_idle_entry_timer;
	logic [11:0] standby_entry_timer;
	logic [11:0] next_standby_entry_timer;
	logic [5:0] power_fsm_state_code;
	logic [5:0] next_power_fsm_state_code;
	logic [3:0] marker;
	logic [3:0] next_marker;
	logic [3:0] intx;
	logic [3:0] next_intx;
	logic halt;
	logic next_halt;
	logic unlock;
	logic next_unlock;
	logic strict;
	logic next_strict;
	logic rst_pulse;
	logic next_rst_pulse;
	logic ack;
	logic next_ack;
	logic [31:0] rdata;
	logic [31:0] next_rdata;

	// access decode
	logic wr;
	logic [31:0] wmask;
	logic [31:0] wd;
	logic [31:0] rd_mux;
	assign wr = cfg_req_i & cfg_we_i;
	assign wmask = swpm_mask(cfg_be_i);
	assign wd = cfg_wdata_i & wmask;

	// read data assembly; unlisted bits are constant zero
	always_comb begin
		rd_mux = 32'h0;
		if (swpm_hit(cfg_addr_i, `SWPM_OFS_PM_CAPABILITIES)) begin
			rd_mux[7:0] = `SWPM_CAP_ID;
			rd_mux[15:8] = `SWPM_NEXT_PTR;
			rd_mux[18:16] = `SWPM_PM_VER;
			rd_mux[`SWPM_DEVICE_SPECIFIC_INIT_FLAG_BIT] = device_specific_init_flag;
			rd_mux[26:25] = 2'h0;
			rd_mux[31:27] = `SWPM_PME_SUPPORT;
		end else if (swpm_hit(cfg_addr_i, `SWPM_OFS_PM_CONTROL_STATUS)) begin
			rd_mux[1:0] = port_power_state;
			rd_mux[`SWPM_WAKE_MESSAGE_ENABLE_BIT] = wake_message_enable;
			rd_mux[`SWPM_WAKE_MESSAGE_STATUS_BIT] = wake_message_status;
			rd_mux[14:9] = 6'h0;
			rd_mux[31:24] = 8'h0;
		end else if (swpm_hit(cfg_addr_i, `SWPM_OFS_PM_VENDOR_TIMERS_OR_STATE)) begin
			rd_mux[`SWPM_MCS_BIT] = layout_sel;
			if (!layout_sel) begin
				rd_mux[15:0] = deep_idle_entry_timer;
				rd_mux[27:16] = standby_entry_timer;
				rd_mux[30:28] = 3'h0;
			end else begin
				rd_mux[5:0] = power_fsm_state_code;
			end
		end else if (swpm_hit(cfg_addr_i, `SWPM_OFS_SWITCH_STATUS)) begin
			rd_mux[3:0] = straps[3:0];
			rd_mux[11:4] = straps[11:4];
			rd_mux[16:13] = marker;
			rd_mux[23:20] = intx;
		end else if (swpm_hit(cfg_addr_i, `SWPM_OFS_SWITCH_CONTROL)) begin
			rd_mux[`SWPM_CTL_RST_BIT] = 1'b0;
			rd_mux[`SWPM_CTL_HALT_BIT] = halt;
			rd_mux[`SWPM_CTL_UNLOCK_BIT] = unlock;
			rd_mux[`SWPM_CTL_STRICT_BIT] = strict;
		end
	end

	// boot sequencer: straps sampled once the synchroniser has settled
	always_comb begin
		next_boot = boot;
		next_settle = settle;
		next_straps = straps;
		unique case (boot)
			SWPM_ST_SETTLE: begin
				next_settle = settle + 2'd1;
				if (settle == 2'(`SWPM_SYNC_SETTLE - 1)) begin
					next_boot = SWPM_ST_CAPTURE;
				end
			end
			SWPM_ST_CAPTURE: begin
				next_straps = strap_sync;
				next_boot = SWPM_ST_RUN;
			end
			SWPM_ST_RUN: begin
				next_boot = SWPM_ST_RUN;
			end
			default: begin
				next_boot = SWPM_ST_SETTLE;
			end
		endcase
	end

	// register writes and sticky handling
	always_comb begin
		next_device_specific_init_flag = device_specific_init_flag;
		next_port_power_state = port_power_state;
		next_wake_message_enable = wake_message_enable;
		next_layout_sel = layout_sel;
		next_deep_idle_entry_timer = deep_idle_entry_timer;
		next_standby_entry_timer = standby_entry_timer;
		next_marker = marker;
		next_halt = halt;
		next_unlock = unlock;
		next_strict = strict;
		next_rst_pulse = 1'b0;
		// hold bit follows the strap while the strap is being captured
		if (boot == SWPM_ST_CAPTURE) begin
			next_halt = strap_sync[11];
		end
		if (wr && swpm_hit(cfg_addr_i, `SWPM_OFS_PM_CAPABILITIES) && unlock && wmask[`SWPM_DEVICE_SPECIFIC_INIT_FLAG_BIT]) begin
			next_device_specific_init_flag = wd[`SWPM_DEVICE_SPECIFIC_INIT_FLAG_BIT];
		end
		if (wr && swpm_hit(cfg_addr_i, `SWPM_OFS_PM_CONTROL_STATUS)) begin
			// reserved d1/d2 codes leave the state as it was
			if (wmask[0] && (wd[1:0] == `SWPM_PS_D0 || wd[1:0] == `SWPM_PS_D3HOT)) begin
				next_port_power_state = wd[1:0];
			end
			if (wmask[`SWPM_WAKE_MESSAGE_ENABLE_BIT]) begin
				next_wake_message_enable = wd[`SWPM_WAKE_MESSAGE_ENABLE_BIT];
			end
		end
		if (wr && swpm_hit(cfg_addr_i, `SWPM_OFS_PM_VENDOR_TIMERS_OR_STATE)) begin
			if (wmask[`SWPM_MCS_BIT]) begin
				next_layout_sel = wd[`SWPM_MCS_BIT];
			end
			// timers are hidden in the state layout, so writes there skip them
			if (!layout_sel) begin
				next_deep_idle_entry_timer = (deep_idle_entry_timer & ~wmask[15:0]) | wd[15:0];
				next_standby_entry_timer = (standby_entry_timer & ~wmask[27:16]) | wd[27:16];
			end
		end
		if (wr && swpm_hit(cfg_addr_i, `SWPM_OFS_SWITCH_STATUS)) begin
			next_marker = (marker & ~wmask[16:13]) | wd[16:13];
		end
		if (wr && swpm_hit(cfg_addr_i, `SWPM_OFS_SWITCH_CONTROL) && wmask[7:0] == 8'hff) begin
			next_rst_pulse = wd[`SWPM_CTL_RST_BIT];
			// only while still halted or during eeprom load
			if (halt || eeprom_init_i) begin
				next_halt = wd[`SWPM_CTL_HALT_BIT];
			end
			next_unlock = wd[`SWPM_CTL_UNLOCK_BIT];
			next_strict = wd[`SWPM_CTL_STRICT_BIT];
		end
		// hot reset clears non-sticky state; wake enable, wake status, marker, hold and unlock stay
		if (hot_reset_i) begin
			next_device_specific_init_flag = 1'b0;
			next_port_power_state = `SWPM_PS_D0;
			next_layout_sel = 1'b0;
			next_deep_idle_entry_timer = `SWPM_DEEP_IDLE_ENTRY_TIMER_RST;
			next_standby_entry_timer = `SWPM_STANDBY_ENTRY_TIMER_RST;
			next_strict = 1'b0;
			next_rst_pulse = 1'b0;
		end
	end

	// wake status: set beats a same-cycle write-one clear
	always_comb begin
		next_wake_message_status = wake_message_status;
		if (wr && swpm_hit(cfg_addr_i, `SWPM_OFS_PM_CONTROL_STATUS) && wd[`SWPM_WAKE_MESSAGE_STATUS_BIT]) begin
			next_wake_message_status = 1'b0;
		end
		if (pme_generate_i) begin
			next_wake_message_status = 1'b1;
		end
		if (PORT_IS_A) begin
			next_wake_message_status = 1'b0;
		end
	end

	// sampled core status and access answer
	always_comb begin
		next_power_fsm_state_code = power_fsm_state_code_i;
		next_intx = intx_state_i;
		next_ack = cfg_req_i;
		next_rdata = (cfg_req_i && !cfg_we_i) ? rd_mux : rdata;
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			boot <= SWPM_ST_SETTLE;
			settle <= 2'd0;
			straps <= 12'h000;
			device_specific_init_flag <= 1'b0;
			port_power_state <= `SWPM_PS_D0;
			wake_message_enable <= 1'b0;
			wake_message_status <= 1'b0;
			layout_sel <= 1'b0;
			deep_idle_entry_timer <= `SWPM_DEEP_IDLE_ENTRY_TIMER_RST;
			standby_entry_timer <= `SWPM_STANDBY_ENTRY_TIMER_RST;
			power_fsm_state_code <= `SWPM_POWER_FSM_STATE_CODE_RST;
			marker <= 4'h0;
			intx <= 4'h0;
			halt <= 1'b0;
			unlock <= `SWPM_UNLOCK_RST;
			strict <= 1'b0;
			rst_pulse <= 1'b0;
			ack <= 1'b0;
			rdata <= 32'h0;
		end else if (clk_en_i) begin
			boot <= next_boot;
			settle <= next_settle;
			straps <= next_straps;
			device_specific_init_flag <= next_device_specific_init_flag;
			port_power_state <= next_port_power_state;
			wake_message_enable <= next_wake_message_enable;
			wake_message_status <= next_wake_message_status;
			layout_sel <= next_layout_sel;
			deep_idle_entry_timer <= next_deep_idle_entry_timer;
			standby_entry_timer <= next_standby_entry_timer;
			power_fsm_state_code <= next_power_fsm_state_code;
			marker <= next_marker;
			intx <= next_intx;
			halt <= next_halt;
			unlock <= next_unlock;
			strict <= next_strict;
			rst_pulse <= next_rst_pulse;
			ack <= next_ack;
			rdata <= next_rdata;
		end
	end

	// entry timers: standby counts nanoseconds, deep idle counts microseconds
	logic [15:0] ns_cnt;
	logic [15:0] next_ns_cnt;
	logic [15:0] ns_limit;
	logic [7:0] pre_cnt;
	logic [7:0] next_pre_cnt;
	logic [15:0] us_cnt;
	logic [15:0] next_us_cnt;
	logic stby;
	logic next_stby;
	logic deep;
	logic next_deep;
	assign ns_limit = {2'b00, standby_entry_timer, 2'b00}; // units of 4 ns

	always_comb begin
		next_ns_cnt = ns_cnt;
		next_stby = stby;
		if (!standby_cond_i || halt) begin
			next_ns_cnt = 16'h0;
			next_stby = 1'b0;
		end else if (ns_cnt >= ns_limit) begin
			next_stby = 1'b1;
		end else begin
			next_ns_cnt = ns_cnt + CLK_NS;
		end
	end

	// downstream ports never raise deep idle entry
	always_comb begin
		next_pre_cnt = pre_cnt;
		next_us_cnt = us_cnt;
		next_deep = deep;
		if (!deep_idle_cond_i || halt || !IS_UPSTREAM) begin
			next_pre_cnt = 8'h0;
			next_us_cnt = 16'h0;
			next_deep = 1'b0;
		end else if (us_cnt >= deep_idle_entry_timer) begin
			next_deep = 1'b1;
		end else if (pre_cnt == US_LAST) begin
			next_pre_cnt = 8'h0;
			next_us_cnt = us_cnt + 16'h1;
		end else begin
			next_pre_cnt = pre_cnt + 8'h1;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ns_cnt <= 16'h0;
			pre_cnt <= 8'h0;
			us_cnt <= 16'h0;
			stby <= 1'b0;
			deep <= 1'b0;
		end else if (clk_en_i) begin
			ns_cnt <= next_ns_cnt;
			pre_cnt <= next_pre_cnt;
			us_cnt <= next_us_cnt;
			stby <= next_stby;
			deep <= next_deep;
		end
	end

	// outputs; core stays held until the straps are in
	assign cfg_ack_o = ack;
	assign cfg_rdata_o = rdata;
	assign soft_reset_req_o = rst_pulse;
	assign hold_in_reset_o = halt | (boot != SWPM_ST_RUN);
	assign write_protect_release_o = unlock;
	assign strict_ordering_force_o = strict;
	assign port_power_state_o = port_power_state;
	assign wake_message_enable_o = wake_message_enable;
	assign standby_enter_o = stby;
	assign deep_idle_enter_o = deep;
endmodule

// ==== verification/swpm_regs_asserts.sv ====
// checker: port-level relations of the swpm register block
// assumes a bind onto swpm_regs, one clock, reset_n_i async active low
`timescale 1ns/1ps
module swpm_regs_asserts (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic clk_en_i,
	input wire logic hot_reset_i,
	// config access
	input wire logic cfg_req_i,
	input wire logic cfg_we_i,
	input wire logic [7:0] cfg_addr_i,
	input wire logic [3:0] cfg_be_i,
	input wire logic [31:0] cfg_wdata_i,
	input wire logic cfg_ack_o,
	input wire logic [31:0] cfg_rdata_o,
	// status and controls
	input wire logic [3:0] intx_state_i,
	input wire logic standby_cond_i,
	input wire logic soft_reset_req_o,
	input wire logic write_protect_release_o,
	input wire logic strict_ordering_force_o,
	input wire logic [1:0] port_power_state_o,
	input wire logic standby_enter_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// decoded accesses, word select by address bits 7:2
	wire logic rd = cfg_req_i && clk_en_i && !cfg_we_i;
	wire logic ctl_wr = cfg_req_i && clk_en_i && cfg_we_i && cfg_addr_i[7:2] == 6'h29 && cfg_be_i[0];
	chk_ack_one_cycle: assert property (cfg_req_i && clk_en_i |=> cfg_ack_o)
		else $error("no ack after request");
	chk_cap_fixed: assert property (rd && cfg_addr_i[7:2] == 6'h1c |=>
		cfg_rdata_o[31:22] == 10'h320 && cfg_rdata_o[20:0] == 21'h020001)
		else $error("capability word wrong");
	chk_csr_reserved: assert property (rd && cfg_addr_i[7:2] == 6'h1d |=>
		cfg_rdata_o[31:16] == 16'h0 && cfg_rdata_o[14:9] == 6'h0 && cfg_rdata_o[7:2] == 6'h0)
		else $error("pm control reserved bits set");
	chk_layout_zero: assert property (rd && cfg_addr_i[7:2] == 6'h1e |=>
		(cfg_rdata_o[31] ? cfg_rdata_o[30:6] == 25'h0 : cfg_rdata_o[30:28] == 3'h0))
		else $error("layout reserved bits set");
	chk_intx_view: assert property (rd && cfg_addr_i[7:2] == 6'h28 && $stable(intx_state_i) |=>
		cfg_rdata_o[23:20] == $past(intx_state_i) && cfg_rdata_o[31:24] == 8'h0)
		else $error("interrupt state wrong");
	chk_rst_reads_zero: assert property (rd && cfg_addr_i[7:2] == 6'h29 |=>
		cfg_rdata_o[0] == 1'b0 && cfg_rdata_o[31:4] == 28'h0)
		else $error("control reads nonzero reset bit");
	chk_reset_pulse: assert property (soft_reset_req_o == $past(ctl_wr && cfg_wdata_i[0] && !hot_reset_i))
		else $error("soft reset pulse wrong");
	chk_ctl_bits: assert property (ctl_wr && !hot_reset_i |=>
		strict_ordering_force_o == $past(cfg_wdata_i[3])
		&& write_protect_release_o == $past(cfg_wdata_i[2]))
		else $error("control bits not taken");
	chk_state_legal: assert property (port_power_state_o != 2'h1 && port_power_state_o != 2'h2)
		else $error("reserved power state");
	chk_standby_drop: assert property ($fell(standby_cond_i) |=> !standby_enter_o)
		else $error("standby entry held");
	// main scenarios
	cover property (ctl_wr && cfg_wdata_i[0]);
	cover property (rd && cfg_addr_i[7:2] == 6'h1e ##1 cfg_rdata_o[31]);
	cover property ($fell(standby_cond_i) && standby_enter_o);
endmodule

// ==== verification/tb_swpm_regs.sv ====
// testbench: directed config-port scenarios for swpm_regs
// assumes a shortened microsecond tick and the checker bound at the foot
`timescale 1ns/1ps
module tb_swpm_regs;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic hot_reset_i, cfg_req_i, cfg_we_i, eeprom_init_i, pme_generate_i;
	logic standby_cond_i, deep_idle_cond_i;
	logic [7:0] cfg_addr_i;
	logic [3:0] cfg_be_i, intx_state_i;
	logic [31:0] cfg_wdata_i, cfg_rdata_o, rd;
	logic [5:0] power_fsm_state_code_i;
	logic [11:0] strap;
	logic cfg_ack_o, soft_reset_req_o, hold_in_reset_o, write_protect_release_o;
	logic strict_ordering_force_o, wake_message_enable_o, standby_enter_o, deep_idle_enter_o;
	logic [1:0] port_power_state_o;
	int err_count = 0;
	int samples_checked = 0;
	int n;
	swpm_regs #(.US_CYCLES(2)) u_swpm_regs (.clk_i, .reset_n_i, .clk_en_i(1'b1), .hot_reset_i,
		.cfg_req_i, .cfg_we_i, .cfg_addr_i, .cfg_be_i, .cfg_wdata_i, .cfg_ack_o, .cfg_rdata_o,
		.switch_operating_mode_i(strap[3:0]), .shared_refclk_downstream_i(strap[4]),
		.shared_refclk_upstream_i(strap[5]), .host_smbus_slow_strap_i(strap[6]),
		.port_a_lane_flip_i(strap[7]), .port_b_lane_flip_i(strap[8]),
		.port_c_lane_flip_i(strap[9]), .refclk_mode_strap_i(strap[10]),
		.hold_in_reset_i(strap[11]), .eeprom_init_i, .pme_generate_i, .power_fsm_state_code_i,
		.intx_state_i, .standby_cond_i, .deep_idle_cond_i, .soft_reset_req_o, .hold_in_reset_o,
		.write_protect_release_o, .strict_ordering_force_o, .port_power_state_o,
		.wake_message_enable_o, .standby_enter_o, .deep_idle_enter_o);
	// free-running 200 MHz clock
	always #2.5 clk_i = ~clk_i;
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// bounded wait for a level; running out ends the run
	task automatic wait_hi(ref logic s, output int k);
		k = 0;
		while (s !== 1'b1 && k < 50) begin
			@(posedge clk_i);
			#1;
			k++;
		end
		if (k >= 50) begin
			check(32'(s), 32'h1, "wait timed out");
			end_sim();
		end
	endtask
	// one access; the request stays up so the next one can follow back to back
	// the previous ack may still stand, so the taking edge always passes first
	task automatic cfg(input logic we, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be = 4'hf);
		cfg_req_i = 1'b1;
		cfg_we_i = we;
		cfg_addr_i = a;
		cfg_wdata_i = d;
		cfg_be_i = be;
		@(posedge clk_i);
		#1;
		wait_hi(cfg_ack_o, n);
		rd = cfg_rdata_o;
	endtask
	task automatic idle(input int k);
		cfg_req_i = 1'b0;
		repeat (k) begin
			@(posedge clk_i);
			#1;
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
		cfg(1'b0, a, 32'h0);
		check(rd, exp, what);
	endtask
	task automatic do_reset();
		cfg_req_i = 1'b0;
		reset_n_i = 1'b0;
		repeat (8) @(posedge clk_i);
		#1;
		reset_n_i = 1'b1;
		idle(4);
	endtask
	task automatic test_reset_vals();
		rdchk(8'h70, 32'hc8020001, "capability");
		rdchk(8'h74, 32'h0, "pm control");
		rdchk(8'h78, 32'h06d603e8, "timers");
		rdchk(8'ha4, 32'h4, "switch control");
		strap = ~strap; // pin changes after reset must not reach the status word
		idle(3);
		rdchk(8'ha0, 32'h553, "straps");
		check(32'(hold_in_reset_o), 32'h0, "hold after boot");
		$display("test reset_vals done");
	endtask
	task automatic test_fields();
		cfg(1'b1, 8'h74, 32'hffffffff);
		rdchk(8'h74, 32'h103, "state d3hot");
		check(32'({port_power_state_o, wake_message_enable_o}), 32'h7, "pm outputs");
		for (int i = 1; i < 3; i++) begin
			cfg(1'b1, 8'h74, 32'h100 | i);
			rdchk(8'h74, 32'h103, "reserved state");
		end
		cfg(1'b1, 8'h74, 32'h100);
		rdchk(8'h74, 32'h100, "state d0");
		intx_state_i = 4'ha;
		cfg(1'b1, 8'ha0, 32'hffffffff);
		rdchk(8'ha0, 32'h00a1e553, "marker and intx");
		cfg(1'b1, 8'h70, 32'hffffffff);
		rdchk(8'h70, 32'hc8220001, "unlocked write");
		cfg(1'b1, 8'ha4, 32'h0);
		check(32'(write_protect_release_o), 32'h0, "locked output");
		cfg(1'b1, 8'h70, 32'h0);
		rdchk(8'h70, 32'hc8220001, "locked write");
		cfg(1'b1, 8'ha4, 32'hf);
		check(32'(soft_reset_req_o), 32'h1, "soft reset pulse");
		check(32'(strict_ordering_force_o), 32'h1, "strict ordering");
		rdchk(8'ha4, 32'hc, "control");
		cfg(1'b1, 8'ha4, 32'h0, 4'he);
		rdchk(8'ha4, 32'hc, "lane 0 disabled");
		cfg(1'b1, 8'h7c, 32'hffffffff);
		rdchk(8'h7c, 32'h0, "unmapped");
		eeprom_init_i = 1'b1;
		cfg(1'b1, 8'ha4, 32'h6);
		check(32'(hold_in_reset_o), 32'h1, "hold set in init");
		eeprom_init_i = 1'b0;
		cfg(1'b1, 8'ha4, 32'h4);
		check(32'(hold_in_reset_o), 32'h0, "hold cleared");
		$display("test fields done");
	endtask
	task automatic test_pme_hot();
		cfg(1'b1, 8'h74, 32'h103);
		pme_generate_i = 1'b1;
		idle(1);
		pme_generate_i = 1'b0;
		rdchk(8'h74, 32'h8103, "own wake");
		idle(1);
		hot_reset_i = 1'b1;
		idle(2);
		hot_reset_i = 1'b0;
		rdchk(8'h74, 32'h8100, "after hot reset");
		rdchk(8'ha0, 32'h00a1e553, "marker kept");
		cfg(1'b1, 8'h74, 32'h8000);
		rdchk(8'h74, 32'h0, "wake cleared");
		pme_generate_i = 1'b1;
		idle(1);
		pme_generate_i = 1'b0;
		rdchk(8'h74, 32'h8000, "wake while disabled");
		pme_generate_i = 1'b1;
		cfg(1'b1, 8'h74, 32'h8000);
		pme_generate_i = 1'b0;
		rdchk(8'h74, 32'h8000, "set beats clear");
		cfg(1'b1, 8'h74, 32'h8000);
		$display("test pme_hot done");
	endtask
	task automatic test_layout();
		// the timer fields are live in the timer layout, so rewrite their defaults
		cfg(1'b1, 8'h78, 32'h86d603e8);
		rdchk(8'h78, 32'h8000001a, "state deep idle");
		power_fsm_state_code_i = 6'h3f;
		idle(2);
		rdchk(8'h78, 32'h8000003f, "state link down");
		cfg(1'b1, 8'h78, 32'h7fffffff);
		rdchk(8'h78, 32'h06d603e8, "timers kept");
		$display("test layout done");
	endtask
	task automatic test_timers();
		int m;
		cfg(1'b1, 8'h78, 32'h00010002);
		idle(1);
		standby_cond_i = 1'b1;
		deep_idle_cond_i = 1'b1;
		wait_hi(standby_enter_o, m);
		check(32'(m), 32'h2, "standby delay");
		wait_hi(deep_idle_enter_o, n);
		check(32'(m + n), 32'h5, "deep idle delay");
		standby_cond_i = 1'b0;
		deep_idle_cond_i = 1'b0;
		idle(1);
		check(32'(standby_enter_o), 32'h0, "standby exit");
		$display("test timers done");
	endtask
	task automatic test_hold();
		strap = 12'h800;
		do_reset();
		check(32'(hold_in_reset_o), 32'h1, "held by strap");
		rdchk(8'ha4, 32'h6, "halt bit");
		cfg(1'b1, 8'ha4, 32'h4);
		check(32'(hold_in_reset_o), 32'h0, "released");
		$display("test hold done");
	endtask
	// main sequence
	initial begin
		{hot_reset_i, cfg_req_i, cfg_we_i, eeprom_init_i, pme_generate_i} = 5'h0;
		{standby_cond_i, deep_idle_cond_i, cfg_addr_i, cfg_be_i, cfg_wdata_i} = 46'h0;
		intx_state_i = 4'h0;
		power_fsm_state_code_i = 6'h1a;
		strap = 12'h553;
		do_reset();
		test_reset_vals();
		test_fields();
		test_pme_hot();
		test_layout();
		test_timers();
		test_hold();
		idle(2);
		end_sim();
	end
endmodule
bind swpm_regs swpm_regs_asserts u_swpm_regs_asserts (.clk_i, .reset_n_i, .clk_en_i,
	.hot_reset_i, .cfg_req_i, .cfg_we_i, .cfg_addr_i, .cfg_be_i, .cfg_wdata_i, .cfg_ack_o,
	.cfg_rdata_o, .intx_state_i, .standby_cond_i, .soft_reset_req_o, .write_protect_release_o,
	.strict_ordering_force_o, .port_power_state_o, .standby_enter_o);
